/* File: src/hcp_pkg.sv */
package hcp_pkg;

    localparam int ADDR_W     = 4;
    localparam int DATA_W     = 16;
    localparam int REG_DEPTH  = 16;
    localparam int SYNC_DEPTH = 2;
    localparam int COMMIT_MAX = 2;

    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 4'h0;

    typedef struct packed {
        logic              cs_b;
        logic              oe_b;
        logic              rw;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } host_pins_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } wr_word_t;

    localparam host_pins_t PINS_IDLE = '{cs_b: 1'b1, oe_b: 1'b1, rw: 1'b1,
                                         addr: ADDR_RST, data: DATA_RST};
    localparam wr_word_t   WORD_RST  = '{addr: ADDR_RST, data: DATA_RST};

endpackage : hcp_pkg

/* File: src/hcp_reg_mem.sv */
`timescale 1ns/100ps

module hcp_reg_mem
    import hcp_pkg::*;
(
    input  wire logic              i_mclk,
    input  wire logic              i_we,
    input  wire logic [ADDR_W-1:0] i_waddr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic [ADDR_W-1:0] i_raddr,
    output logic      [DATA_W-1:0] o_rdata
);

    // Contents have no reset; software is expected to write before reading.
    logic [DATA_W-1:0] mem [REG_DEPTH];

    always_ff @(posedge i_mclk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk) begin
        o_rdata <= mem[i_raddr];
    end

endmodule : hcp_reg_mem

/* File: src/host_cpu_port.sv */
`timescale 1ns/100ps

// Contract
// - One decoder serves combined-line and separate-strobe hosts, no style pin.
// - Read drives addressed register when select, output enable low, direction high.
// - Write captures bus into pre-load on first rise of direction or select.
// - Pre-load moves into addressed register within 2 system clocks.
// - Read data stays driven until select or output enable rises.
module host_cpu_port
    import hcp_pkg::*;
(
    input  wire logic              i_mclk,
    input  wire logic              i_rst_b,
    input  wire logic              i_cs_b,
    input  wire logic              i_oe_b,
    input  wire logic              i_rw,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_data,
    output logic      [DATA_W-1:0] o_data,
    output logic                   o_data_oe,
    output logic                   o_wr_pulse,
    output logic      [ADDR_W-1:0] o_wr_addr,
    output logic      [DATA_W-1:0] o_wr_data
);

    host_pins_t        pins_in;
    host_pins_t        sync1_r;
    host_pins_t        sync2_r;
    logic              rd_act;
    logic              wr_act;
    logic              rd_d1_r;
    logic              wr_d1_r;
    logic              wr_end;
    wr_word_t          hold_r;
    wr_word_t          preload_r;
    logic              wr_go_r;
    logic [DATA_W-1:0] rdata;

    assign pins_in = '{cs_b: i_cs_b, oe_b: i_oe_b, rw: i_rw, addr: i_addr, data: i_data};

    // The host pins are asynchronous to the system clock, so every pin is
    // resynchronised; the first stage feeds nothing but the second.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1_r <= PINS_IDLE;
            sync2_r <= PINS_IDLE;
        end else begin
            sync1_r <= pins_in;
            sync2_r <= sync1_r;
        end
    end

    // Combined-line hosts hold output enable low, so the same terms decode both styles.
    assign rd_act = !sync2_r.cs_b && !sync2_r.oe_b && sync2_r.rw;
    assign wr_act = !sync2_r.cs_b && !sync2_r.rw;
    assign wr_end = wr_d1_r && !wr_act;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_d1_r <= 1'b0;
            wr_d1_r <= 1'b0;
        end else begin
            rd_d1_r <= rd_act;
            wr_d1_r <= wr_act;
        end
    end

    // Track the bus while the write is open so the value seen just before the
    // closing edge is kept, even though the host may drop data right after it.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hold_r <= WORD_RST;
        end else if (wr_act) begin
            hold_r <= '{addr: sync2_r.addr, data: sync2_r.data};
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            preload_r <= WORD_RST;
            wr_go_r   <= 1'b0;
        end else begin
            wr_go_r <= wr_end;
            if (wr_end) begin
                preload_r <= hold_r;
            end
        end
    end

    hcp_reg_mem u_reg_mem (
        .i_mclk  (i_mclk),
        .i_we    (wr_go_r),
        .i_waddr (preload_r.addr),
        .i_wdata (preload_r.data),
        .i_raddr (sync2_r.addr),
        .o_rdata (rdata)
    );

    // The bus is only enabled once the registered read data has caught up
    // with the address, and is dropped as soon as the read decode falls.
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_data    <= DATA_RST;
            o_data_oe <= 1'b0;
        end else begin
            o_data    <= rdata;
            o_data_oe <= rd_act && rd_d1_r;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wr_pulse <= 1'b0;
            o_wr_addr  <= ADDR_RST;
            o_wr_data  <= DATA_RST;
        end else begin
            o_wr_pulse <= wr_go_r;
            if (wr_go_r) begin
                o_wr_addr <= preload_r.addr;
                o_wr_data <= preload_r.data;
            end
        end
    end

    sequence s_write_close;
        wr_d1_r ##0 !wr_act;
    endsequence

    sequence s_read_open;
        rd_act ##1 rd_act;
    endsequence

    sequence s_pins_read;
        !i_cs_b && !i_oe_b && i_rw;
    endsequence

    sequence s_pins_write;
        !i_cs_b && !i_rw;
    endsequence

    sequence s_read_held;
        o_data_oe && rd_act;
    endsequence

    // Both host styles must reach the one decoder after exactly two resync stages.
    property p_style_share;
        @(posedge i_mclk) disable iff (!i_rst_b)
        s_pins_read |-> ##2 (rd_act && !wr_act);
    endproperty
    a_style_share: assert property (p_style_share)
        else $error("read decode missed for shared pins");

    property p_decode_excl;
        @(posedge i_mclk) disable iff (!i_rst_b)
        wr_act |=> !o_data_oe && !wr_go_r;
    endproperty
    a_decode_excl: assert property (p_decode_excl)
        else $error("read and write decoded together");

    property p_read_drive;
        @(posedge i_mclk) disable iff (!i_rst_b)
        s_read_open |=> o_data_oe && o_data == $past(rdata);
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("read data not driven");

    property p_read_release;
        @(posedge i_mclk) disable iff (!i_rst_b)
        $fell(rd_act) |=> !o_data_oe;
    endproperty
    a_read_release: assert property (p_read_release)
        else $error("data bus not released after read end");

    property p_capture;
        @(posedge i_mclk) disable iff (!i_rst_b)
        s_write_close |=> preload_r == $past(hold_r) && wr_go_r;
    endproperty
    a_capture: assert property (p_capture)
        else $error("pre-load not captured at write close");

    property p_commit;
        @(posedge i_mclk) disable iff (!i_rst_b)
        s_write_close |-> ##[1:2] (o_wr_pulse && o_wr_data == preload_r.data);
    endproperty
    a_commit: assert property (p_commit)
        else $error("write not committed within two clocks");

    property p_write_decode;
        @(posedge i_mclk) disable iff (!i_rst_b)
        s_pins_write |-> ##2 (wr_act && !rd_act);
    endproperty
    a_write_decode: assert property (p_write_decode)
        else $error("write decode missed for shared pins");

    property p_pulse_once;
        @(posedge i_mclk) disable iff (!i_rst_b)
        o_wr_pulse |=> !o_wr_pulse;
    endproperty
    a_pulse_once: assert property (p_pulse_once)
        else $error("write pulse longer than one clock");

    property p_wr_held;
        @(posedge i_mclk) disable iff (!i_rst_b)
        !wr_go_r |=> $stable(o_wr_addr) && $stable(o_wr_data);
    endproperty
    a_wr_held: assert property (p_wr_held)
        else $error("committed write word changed without a commit");

    property p_preload_hold;
        @(posedge i_mclk) disable iff (!i_rst_b)
        !wr_end |=> $stable(preload_r);
    endproperty
    a_preload_hold: assert property (p_preload_hold)
        else $error("pre-load changed outside a write close");

    property p_read_hold;
        @(posedge i_mclk) disable iff (!i_rst_b)
        s_read_held |=> o_data_oe;
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("data bus dropped while the read is still open");

    property p_oe_from_read;
        @(posedge i_mclk) disable iff (!i_rst_b)
        o_data_oe |-> $past(rd_act) && $past(rd_act, 2);
    endproperty
    a_oe_from_read: assert property (p_oe_from_read)
        else $error("data bus driven without a settled read");

endmodule : host_cpu_port

/* File: verification/host_model.sv */
`timescale 1ns/100ps

module host_model
    import hcp_pkg::*;
(
    input  wire logic              i_mclk,
    output logic                   o_cs_b,
    output logic                   o_oe_b,
    output logic                   o_rw,
    output logic      [ADDR_W-1:0] o_addr,
    output logic      [DATA_W-1:0] o_data
);
    initial {o_cs_b, o_oe_b, o_rw, o_addr, o_data} = PINS_IDLE;

    task automatic step(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : step

    task automatic wr(input logic sep, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        step(1);
        {o_oe_b, o_rw, o_addr, o_data} = {sep, 1'b0, a, d};
        o_cs_b = 1'b0;
        step(3);
        if (sep) o_rw = 1'b1; else o_cs_b = 1'b1;
        step(1);
        // A released bus shows the inverse so a stale word cannot pass as captured.
        {o_cs_b, o_rw, o_data} = {2'b11, ~d};
        step(2);
    endtask : wr

    task automatic rd_open(input logic [ADDR_W-1:0] a);
        step(1);
        {o_oe_b, o_rw, o_addr, o_data} = {1'b0, 1'b1, a, ~o_data};
        o_cs_b = 1'b0;
    endtask : rd_open

    task automatic rd_close(input logic sep);
        step(1);
        if (sep) o_oe_b = 1'b1; else o_cs_b = 1'b1;
    endtask : rd_close

    task automatic idle(input logic sep);
        step(1);
        {o_cs_b, o_oe_b} = {1'b1, sep};
    endtask : idle
endmodule : host_model

/* File: verification/testbench.sv */
`timescale 1ns/100ps

module testbench import hcp_pkg::*;;
    logic              i_mclk = 1'b0;
    logic              i_rst_b = 1'b0;
    logic              cs_b, oe_b, rw, o_data_oe, o_wr_pulse;
    logic [ADDR_W-1:0] addr, o_wr_addr;
    logic [DATA_W-1:0] data, o_data, o_wr_data;
    int                miscompares = 0;
    int                num_checks = 0;

    always #12.5 i_mclk = ~i_mclk;

    host_model host (.i_mclk(i_mclk), .o_cs_b(cs_b), .o_oe_b(oe_b), .o_rw(rw),
                     .o_addr(addr), .o_data(data));
    host_cpu_port DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_cs_b(cs_b), .i_oe_b(oe_b),
                       .i_rw(rw), .i_addr(addr), .i_data(data), .o_data(o_data),
                       .o_data_oe(o_data_oe), .o_wr_pulse(o_wr_pulse),
                       .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data));

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test

    task automatic wait_sig(input logic want_oe, input int exp_n);
        int n;
        for (n = 0; n < 12; n++) begin
            if ((want_oe ? o_data_oe : o_wr_pulse) === 1'b1) break;
            @(posedge i_mclk) #1;
        end
        check("latency", n, exp_n);
        if (n == 12) stop_test();
    endtask : wait_sig

    task automatic do_wr(input logic sep, input logic [3:0] a, input logic [15:0] d);
        host.wr(sep, a, d);
        // The host returns three clocks after closing; the commit shows one clock later.
        wait_sig(1'b0, 1);
        check("wr_addr", o_wr_addr, a);
        check("wr_data", o_wr_data, d);
        check("no_read", o_data_oe, 1'b0);
        @(posedge i_mclk) #1;
        check("wr_pulse_end", o_wr_pulse, 1'b0);
    endtask : do_wr

    task automatic do_rd(input logic sep, input logic [3:0] a, input logic [15:0] exp);
        host.rd_open(a);
        wait_sig(1'b1, 4);
        check("rd_data", o_data, exp);
        host.rd_close(sep);
        @(posedge i_mclk) #1;
        check("rd_hold", o_data_oe, 1'b1);
        repeat (2) @(posedge i_mclk) #1;
        check("rd_release", o_data_oe, 1'b0);
        host.idle(sep);
    endtask : do_rd

    task automatic test_styles;
        do_wr(1'b0, 4'h3, 16'ha5c3);
        do_rd(1'b0, 4'h3, 16'ha5c3);
        do_wr(1'b1, 4'hf, 16'h1234);
        do_rd(1'b1, 4'hf, 16'h1234);
        $display("test styles done");
    endtask : test_styles

    // Mixing styles on one decoder shows that no mode is latched.
    task automatic test_cross;
        do_wr(1'b1, 4'h0, 16'hffff);
        do_wr(1'b0, 4'h1, 16'h0000);
        do_rd(1'b0, 4'h0, 16'hffff);
        do_rd(1'b1, 4'h1, 16'h0000);
        do_rd(1'b0, 4'h3, 16'ha5c3);
        $display("test cross done");
    endtask : test_cross

    // A reset in mid-run must clear every output and leave both host styles usable.
    task automatic test_reset;
        @(posedge i_mclk) #1;
        i_rst_b = 1'b0;
        @(posedge i_mclk) #1;
        check("mid_rst_oe", o_data_oe, 1'b0);
        check("mid_rst_pulse", o_wr_pulse, 1'b0);
        check("mid_rst_waddr", o_wr_addr, ADDR_RST);
        check("mid_rst_wdata", o_wr_data, DATA_RST);
        check("mid_rst_data", o_data, DATA_RST);
        i_rst_b = 1'b1;
        do_wr(1'b0, 4'h5, 16'h5a0f);
        do_rd(1'b1, 4'h5, 16'h5a0f);
        $display("test reset done");
    endtask : test_reset

    initial begin
        repeat (6) @(posedge i_mclk);
        #1;
        check("rst_oe", o_data_oe, 1'b0);
        check("rst_waddr", o_wr_addr, ADDR_RST);
        check("rst_pulse", o_wr_pulse, 1'b0);
        i_rst_b = 1'b1;
        test_styles();
        test_cross();
        test_reset();
        stop_test();
    end
endmodule : testbench
